// *** verilog/amc_pkg.sv ***
// Constants shared by the converter monitor and its testbench.
package amc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_INPUT_CURRENT_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_ALARM0 = 8'h10;
  localparam logic [7:0] OFS_ALARM_LAST = 8'h18;
  localparam logic [7:0] OFS_RESULT0 = 8'h20;
  localparam logic [7:0] OFS_RESULT_LAST = 8'h38;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_MANUAL_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int ST_READY_BIT = 0;
  localparam int ST_IIN_VALID_BIT = 1;
  localparam int ST_REF_LSB = 2;
  localparam int ST_ALARM_LSB = 4;
  localparam int ST_BUSY_BIT = 7;
  localparam int AL_CHAN_LSB = 12;
  localparam int AL_DIR_BIT = 15;
  localparam int AL_EN_BIT = 16;
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam logic [9:0] INPUT_CURRENT_LIMIT_RESET = 10'h064;
  localparam logic [9:0] INPUT_CURRENT_LIMIT_HIGH_RANGE = 10'h096;

  // ----------------------------------------
  // Channels and scaling numerators, result = code * num / 2^16
  // ----------------------------------------
  localparam int NUM_CHAN = 7;
  localparam int NUM_ALARM = 3;
  localparam logic [2:0] CH_VIN = 3'h0;
  localparam logic [2:0] CH_IIN = 3'h1;
  localparam logic [2:0] CH_SYSRAIL = 3'h2;
  localparam logic [2:0] CH_VBAT = 3'h3;
  localparam logic [2:0] CH_THERM = 3'h4;
  localparam logic [2:0] CH_GENERAL = 3'h5;
  localparam logic [2:0] CH_CHG_PCT = 3'h6;
  localparam logic [15:0] NUM_6V_MV = 16'h1770;
  localparam logic [15:0] NUM_1V2_MV = 16'h04B0;
  localparam logic [15:0] NUM_375_MA = 16'h0177;
  localparam logic [15:0] NUM_750_MA = 16'h02EE;
  localparam logic [15:0] NUM_PCT = 16'h007D;
  localparam logic [1:0] REF_FAST = 2'h0;
  localparam logic [1:0] REF_PRECHARGE = 2'h1;
  localparam logic [1:0] REF_COLD = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int REFRESH_MS = 250;
  localparam int REFRESH_CYC = REFRESH_MS * 1000 * CLK_MHZ;
  localparam int SLOT_CYC = REFRESH_CYC / NUM_CHAN;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_WAIT = 2'b10
  } amc_seq_type;
endpackage : amc_pkg

// *** verilog/amc_alarm.sv ***
// One alarm comparator: detects a threshold crossing on its selected channel.
`timescale 1ns/1ps
`default_nettype none
module amc_alarm (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic enable_i,
  input wire logic alarm_direction_select_i,
  input wire logic [2:0] alarm_channel_select_i,
  input wire logic [11:0] alarm_threshold_value_i,
  // New result
  input wire logic result_valid_i,
  input wire logic [2:0] result_chan_i,
  input wire logic prev_known_i,
  input wire logic [11:0] prev_i,
  input wire logic [11:0] newest_i,
  // Crossing pulse
  output logic hit_o
);
  // ----------------------------------------
  // Crossing detection
  // ----------------------------------------
  // Upward: was below and now at or above; downward is the mirror.
  wire logic prev_above = prev_i >= alarm_threshold_value_i;
  wire logic new_above = newest_i >= alarm_threshold_value_i;
  wire logic up_cross = !prev_above && new_above;
  wire logic down_cross = prev_above && !new_above;
  wire logic dir_cross = alarm_direction_select_i ? up_cross : down_cross;
  // No crossing is claimed without an earlier result to compare against.
  wire logic watch = enable_i && result_valid_i && prev_known_i &&
                     (result_chan_i == alarm_channel_select_i);

  // Register the one-cycle hit.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= watch && dir_cross;
    end
  end
endmodule : amc_alarm
`default_nettype wire

// *** verilog/amc_top.sv ***
// Converter monitor: sequencing, result scaling, alarms and AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
module amc_top #(
  parameter int SLOT_CYC = amc_pkg::SLOT_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power state pins
  input wire logic vin_present_i,
  input wire logic vin_in_range_i,
  input wire logic low_power_select_n_i,
  input wire logic precharge_i,
  input wire logic cold_region_i,
  // Converter core, same clock
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  output logic conv_power_o,
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  // Host interrupt, active high level
  output logic irq_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_meta_r;
  logic [4:0] pin_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_meta_r <= 5'h00;
      pin_r <= 5'h00;
    end else begin
      pin_meta_r <= {cold_region_i, precharge_i, low_power_select_n_i,
                     vin_in_range_i, vin_present_i};
      pin_r <= pin_meta_r;
    end
  end
  wire logic vin_on = pin_r[0];
  wire logic in_range = pin_r[1];
  // Low power only matters on battery; input power keeps the converter alive.
  wire logic low_power = !pin_r[2] && !vin_on;
  wire logic [1:0] ref_sel = pin_r[3] ? amc_pkg::REF_PRECHARGE :
                             pin_r[4] ? amc_pkg::REF_COLD : amc_pkg::REF_FAST;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic manual_r;
  logic start_r;
  logic ready_r;
  logic [2:0] alarm_flag_r;
  logic [2:0] mask_r;
  logic [9:0] input_current_limit_r;
  logic [16:0] alarm_cfg_r [amc_pkg::NUM_ALARM];
  logic [15:0] raw_r [amc_pkg::NUM_CHAN];
  logic [amc_pkg::NUM_CHAN-1:0] known_r;
  logic [2:0] hit;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire logic rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  wire logic [7:0] wa = s_axi_awaddr;
  wire logic [7:0] ra = s_axi_araddr;
  wire logic wr_ctrl = wr_go && wa == amc_pkg::OFS_CTRL;
  wire logic wr_status = wr_go && wa == amc_pkg::OFS_STATUS;
  wire logic wr_mask = wr_go && wa == amc_pkg::OFS_MASK;
  wire logic wr_input_current_limit = wr_go && wa == amc_pkg::OFS_INPUT_CURRENT_LIMIT;
  wire logic wr_alarm = wr_go && wa >= amc_pkg::OFS_ALARM0 &&
                        wa <= amc_pkg::OFS_ALARM_LAST && wa[1:0] == 2'h0;
  wire logic [1:0] wr_alarm_idx = 2'((wa - amc_pkg::OFS_ALARM0) >> 2);
  wire logic wr_ok = wr_ctrl || wr_status || wr_mask || wr_input_current_limit || wr_alarm ||
                     (wa >= amc_pkg::OFS_RESULT0 && wa <= amc_pkg::OFS_RESULT_LAST &&
                      wa[1:0] == 2'h0);
  wire logic [31:0] wd = s_axi_wdata;
  wire logic lane0 = s_axi_wstrb[0];
  // Byte enables are honoured only at lane 0, 1 and 2 granularity for these small fields.
  wire logic lane1 = s_axi_wstrb[1];
  wire logic lane2 = s_axi_wstrb[2];

  // Scale a raw code to engineering units for the given channel.
  function automatic logic [15:0] scale(input logic [2:0] ch, input logic [15:0] code,
                                        input logic [9:0] input_current_limit);
    logic [15:0] num;
    logic [31:0] prod;
    num = 16'h0000;
    prod = 32'h0000_0000;
    if (ch == amc_pkg::CH_VIN || ch == amc_pkg::CH_SYSRAIL || ch == amc_pkg::CH_VBAT) begin
      num = amc_pkg::NUM_6V_MV;
    end else if (ch == amc_pkg::CH_THERM || ch == amc_pkg::CH_GENERAL) begin
      num = amc_pkg::NUM_1V2_MV;
    end else if (ch == amc_pkg::CH_IIN) begin
      num = (input_current_limit > amc_pkg::INPUT_CURRENT_LIMIT_HIGH_RANGE) ? amc_pkg::NUM_750_MA
                                             : amc_pkg::NUM_375_MA;
    end else if (ch == amc_pkg::CH_CHG_PCT) begin
      num = amc_pkg::NUM_PCT;
    end
    prod = code * num;
    return prod[31:16];
  endfunction : scale

  // Read mux; result words carry raw code low and scaled value high.
  wire logic rd_res = ra >= amc_pkg::OFS_RESULT0 && ra <= amc_pkg::OFS_RESULT_LAST &&
                      ra[1:0] == 2'h0;
  wire logic [2:0] rd_ch = 3'((ra - amc_pkg::OFS_RESULT0) >> 2);
  wire logic rd_al = ra >= amc_pkg::OFS_ALARM0 && ra <= amc_pkg::OFS_ALARM_LAST &&
                     ra[1:0] == 2'h0;
  wire logic [1:0] rd_al_idx = 2'((ra - amc_pkg::OFS_ALARM0) >> 2);
  wire logic [31:0] status_word = {24'h00_0000, !manual_r || start_r, alarm_flag_r, ref_sel,
                                   vin_on && in_range, ready_r};
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (ra == amc_pkg::OFS_CTRL) begin
      rd_word = {30'h0000_0000, start_r, manual_r};
    end else if (ra == amc_pkg::OFS_STATUS) begin
      rd_word = status_word;
    end else if (ra == amc_pkg::OFS_MASK) begin
      rd_word = {29'h0000_0000, mask_r};
    end else if (ra == amc_pkg::OFS_INPUT_CURRENT_LIMIT) begin
      rd_word = {22'h00_0000, input_current_limit_r};
    end else if (rd_al) begin
      rd_word = {15'h0000, alarm_cfg_r[rd_al_idx]};
    end else if (rd_res) begin
      rd_word = {scale(rd_ch, raw_r[rd_ch], input_current_limit_r), raw_r[rd_ch]};
    end else begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b0;
    end
  end

  // AXI4-Lite handshakes: address and data taken together, answer next cycle.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  amc_pkg::amc_seq_type seq_r;
  logic [31:0] slot_r;
  logic [2:0] chan_r;
  wire logic slot_tick = slot_r == 32'(SLOT_CYC - 1);
  // Free running whenever not in manual battery mode and not in low power.
  wire logic auto_run = !low_power && (vin_on || !manual_r);
  wire logic last_chan = chan_r == 3'(amc_pkg::NUM_CHAN - 1);
  wire logic issue = seq_r == amc_pkg::SEQ_IDLE && !low_power &&
                     ((auto_run && slot_tick) || (start_r && !auto_run));
  wire logic done = seq_r == amc_pkg::SEQ_WAIT && conv_done_i;
  wire logic sweep_end = done && last_chan && start_r && !vin_on;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      seq_r <= amc_pkg::SEQ_IDLE;
      slot_r <= 32'h0000_0000;
      chan_r <= 3'h0;
      conv_start_o <= 1'b0;
      conv_chan_o <= 3'h0;
      conv_power_o <= 1'b0;
    end else begin
      conv_power_o <= !low_power;
      conv_start_o <= issue;
      slot_r <= (slot_tick || !auto_run) ? 32'h0000_0000 : slot_r + 32'h0000_0001;
      case (seq_r)
        amc_pkg::SEQ_IDLE: begin
          if (issue) begin
            conv_chan_o <= chan_r;
            seq_r <= amc_pkg::SEQ_WAIT;
          end
        end
        amc_pkg::SEQ_WAIT: begin
          // Entering low power abandons a conversion in flight.
          if (done || low_power) begin
            chan_r <= last_chan ? 3'h0 : chan_r + 3'h1;
            seq_r <= amc_pkg::SEQ_IDLE;
          end
        end
        default: seq_r <= amc_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Result store; previous value kept for crossing detection.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      known_r <= '0;
    end else if (done) begin
      raw_r[conv_chan_o] <= conv_data_i;
      known_r[conv_chan_o] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Alarm comparators
  // ----------------------------------------
  for (genvar k = 0; k < amc_pkg::NUM_ALARM; k++) begin : g_alarm
    amc_alarm u_alarm (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .enable_i(alarm_cfg_r[k][amc_pkg::AL_EN_BIT]),
      .alarm_direction_select_i(alarm_cfg_r[k][amc_pkg::AL_DIR_BIT]),
      .alarm_channel_select_i(alarm_cfg_r[k][amc_pkg::AL_CHAN_LSB +: 3]),
      .alarm_threshold_value_i(alarm_cfg_r[k][11:0]),
      .result_valid_i(done),
      .result_chan_i(conv_chan_o),
      .prev_known_i(known_r[conv_chan_o]),
      .prev_i(raw_r[conv_chan_o][15:4]),
      .newest_i(conv_data_i[15:4]),
      .hit_o(hit[k])
    );
  end

  // ----------------------------------------
  // Software-visible control
  // ----------------------------------------
  // Hardware sets win over a write-one-to-clear in the same cycle.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      manual_r <= 1'b0;
      start_r <= 1'b0;
      ready_r <= 1'b0;
      alarm_flag_r <= 3'h0;
      mask_r <= amc_pkg::MASK_RESET;
      input_current_limit_r <= amc_pkg::INPUT_CURRENT_LIMIT_RESET;
      irq_o <= 1'b0;
      for (int i = 0; i < amc_pkg::NUM_ALARM; i++) begin
        alarm_cfg_r[i] <= 17'h0_0000;
      end
    end else begin
      if (wr_ctrl && lane0) begin
        manual_r <= wd[amc_pkg::CTRL_MANUAL_BIT];
      end
      // Start clears when the sweep ends, or at once if nothing can serve it.
      if (sweep_end || low_power || vin_on) begin
        start_r <= 1'b0;
      end else if (wr_ctrl && lane0 && wd[amc_pkg::CTRL_START_BIT]) begin
        start_r <= 1'b1;
      end
      ready_r <= sweep_end || (ready_r && !(wr_status && lane0 &&
                 wd[amc_pkg::ST_READY_BIT]));
      alarm_flag_r <= hit | (alarm_flag_r & ~((wr_status && lane0) ?
                      wd[amc_pkg::ST_ALARM_LSB +: 3] : 3'h0));
      if (wr_mask && lane0) begin
        mask_r <= wd[2:0];
      end
      if (wr_input_current_limit && lane0 && lane1) begin
        input_current_limit_r <= wd[9:0];
      end
      if (wr_alarm && lane0 && lane1 && lane2) begin
        alarm_cfg_r[wr_alarm_idx] <= wd[16:0];
      end
      irq_o <= ready_r || |(alarm_flag_r & ~mask_r);
    end
  end
endmodule : amc_top
`default_nettype wire

// *** bench/amc_top_assertions.sv ***
// Concurrent checks on the converter monitor ports, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module amc_top_checker #(
  parameter int SLOT_CYC = 20
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter and interrupt
  input wire logic conv_done_i,
  input wire logic conv_power_o,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic irq_o
);
  // ----------------------------------------
  // Conversion bookkeeping
  // ----------------------------------------
  logic busy_r;
  logic seen_r;
  logic [2:0] last_r;
  logic [2:0] next_chan;
  // The channel after the seventh wraps to the first.
  assign next_chan = (last_r == 3'h6) ? 3'h0 : last_r + 3'h1;
  // Tracks the conversion in flight and the last channel asked for.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      seen_r <= 1'b0;
      last_r <= 3'h0;
    end else begin
      busy_r <= conv_start_o | (busy_r & ~conv_done_i);
      seen_r <= seen_r | conv_start_o;
      last_r <= conv_start_o ? conv_chan_o : last_r;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  AST_WRITE_ANSWER: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered");
  AST_WRITE_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
  AST_READ_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_SINGLE_CONV: assert property (
    conv_start_o |-> !busy_r ##1 !conv_start_o) else $error("second conversion in flight");
  AST_CHAN_ORDER: assert property (
    conv_start_o && seen_r |-> conv_chan_o == next_chan) else $error("channel out of order");
  AST_OFF_NO_START: assert property (
    !conv_power_o |-> !conv_start_o) else $error("conversion while powered down");
  AST_MASKED_AFTER_RESET: assert property (
    $fell(rst_i) |-> !irq_o [*8]) else $error("interrupt right after reset");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst_i |=> !irq_o && !conv_start_o && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active in reset");
endmodule : amc_top_checker
bind amc_top amc_top_checker #(.SLOT_CYC(SLOT_CYC)) u_amc_top_checker (
  .mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_done_i(conv_done_i), .conv_power_o(conv_power_o),
  .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .irq_o(irq_o)
);
`default_nettype wire

// *** bench/tb_amc_top.sv ***
// Self-checking bench for the converter monitor: registers, scaling, alarms, manual mode.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_amc_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic vin_present_i = 1'b1, vin_in_range_i = 1'b1, low_power_select_n_i = 1'b1;
  logic precharge_i = 1'b0, cold_region_i = 1'b0, conv_done_i = 1'b0;
  logic [15:0] conv_data_i = 16'h0;
  logic conv_power_o, conv_start_o, irq_o, fire;
  logic [2:0] conv_chan_o, pend_chan = 3'h0;
  logic [15:0] chan_data [7];
  logic pend = 1'b0;
  int dly = 0, done_cnt = 0, num_errors = 0, checks = 0;

  // A 10 ns period; slots are shortened to 20 cycles to keep sweeps brief.
  always #5 mclk_i = ~mclk_i;
  amc_top #(.SLOT_CYC(20)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .vin_present_i(vin_present_i), .vin_in_range_i(vin_in_range_i),
    .low_power_select_n_i(low_power_select_n_i), .precharge_i(precharge_i),
    .cold_region_i(cold_region_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .conv_power_o(conv_power_o), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
    .irq_o(irq_o)
  );

  // Converter stand-in: answers each start after a random delay; the data lines carry
  // noise between results so a stale value can never pass for a fresh one.
  assign fire = pend && dly == 0;
  always @(posedge mclk_i) begin
    conv_done_i <= fire;
    conv_data_i <= fire ? chan_data[pend_chan] : 16'($urandom);
    if (conv_start_o) begin
      pend <= 1'b1;
      pend_chan <= conv_chan_o;
      dly <= 2 + int'($urandom % 4);
    end else if (fire) begin
      pend <= 1'b0;
      done_cnt <= done_cnt + 1;
    end else if (pend) begin
      dly <= dly - 1;
    end
  end
  // ----------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : settle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // A random late bready makes the slave hold its response for a cycle.
    s_axi_bready <= 1'($urandom);
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // A random late rready makes the slave hold its read data for a cycle.
    s_axi_rready <= 1'($urandom);
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Waits until n more results have come back, so every channel is fresh.
  task automatic wait_done(input int n);
    int t;
    t = done_cnt + n;
    while (done_cnt < t) @(posedge mclk_i);
    settle(4);
  endtask : wait_done
  // Scaled value of a raw code on a channel.
  function automatic logic [15:0] exp_scaled(input int c, input logic [15:0] raw, input logic hi);
    logic [31:0] num;
    case (c)
      0, 2, 3: num = 32'(amc_pkg::NUM_6V_MV);
      4, 5: num = 32'(amc_pkg::NUM_1V2_MV);
      1: num = 32'(hi ? amc_pkg::NUM_750_MA : amc_pkg::NUM_375_MA);
      default: num = 32'(amc_pkg::NUM_PCT);
    endcase
    return 16'((32'(raw) * num) >> 16);
  endfunction : exp_scaled
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // A hang ends the run as a failure; the tests need under two thousand cycles.
  initial begin
    repeat (60000) @(posedge mclk_i);
    num_errors++;
    $display("watchdog expired");
    complete_run();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd, wd;
    logic [1:0] resp;
    logic [11:0] thr [3];
    int k, ph, n;
    void'($urandom(32'hAB93));
    for (k = 0; k < 7; k++) chan_data[k] = 16'h0;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    settle(4);
    axi_rd(amc_pkg::OFS_MASK, rd, resp);
    `CHK("mask", 32'h7, rd)
    // A limit write without lane 1 must be ignored, so the reset value stays.
    s_axi_wstrb <= 4'h1;
    axi_wr(amc_pkg::OFS_INPUT_CURRENT_LIMIT, 32'h3FF, resp);
    s_axi_wstrb <= 4'hF;
    axi_rd(amc_pkg::OFS_INPUT_CURRENT_LIMIT, rd, resp);
    `CHK("input_current_limit", {22'h0, amc_pkg::INPUT_CURRENT_LIMIT_RESET}, rd)
    axi_wr(8'h40, 32'hFFFFFFFF, resp);
    `CHK("bresp", 2'h2, resp)
    axi_rd(8'h40, rd, resp);
    `CHK("rresp", 2'h2, resp)
    $display("register test done");
    for (ph = 0; ph < 2; ph++) begin
      axi_wr(amc_pkg::OFS_INPUT_CURRENT_LIMIT, ph ? 32'h97 : 32'h96, resp);
      for (k = 0; k < 7; k++) chan_data[k] <= (k == ph) ? {16{ph[0]}} : 16'($urandom);
      vin_in_range_i <= ph[0];
      wait_done(8);
      axi_rd(amc_pkg::OFS_STATUS, rd, resp);
      `CHK("current valid", ph[0], rd[1])
      `CHK("ready", 1'b0, rd[0])
      for (k = 0; k < 7; k++) begin
        axi_rd(amc_pkg::OFS_RESULT0 + 8'(4 * k), rd, resp);
        `CHK("raw", chan_data[k], rd[15:0])
        `CHK("scaled", exp_scaled(k, chan_data[k], ph[0]), rd[31:16])
      end
    end
    for (k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      precharge_i <= k[0];
      cold_region_i <= k[1];
      settle(6);
      axi_rd(amc_pkg::OFS_STATUS, rd, resp);
      wd = 32'(k[0] ? amc_pkg::REF_PRECHARGE : (k[1] ? amc_pkg::REF_COLD : amc_pkg::REF_FAST));
      `CHK("ref", wd[1:0], rd[3:2])
    end
    $display("scaling test done");
    // Comparator k watches channel 2k; the middle one looks for a downward crossing.
    // Comparators are still disabled here and every channel holds a fresh result.
    for (k = 0; k < 3; k++) begin
      thr[k] = 12'(($urandom % 4094) + 1);
      wd = 32'(thr[k]) | (32'(k != 1) << amc_pkg::AL_DIR_BIT)
        | (32'(2 * k) << amc_pkg::AL_CHAN_LSB) | (32'h1 << amc_pkg::AL_EN_BIT);
      axi_wr(amc_pkg::OFS_ALARM0 + 8'(4 * k), wd, resp);
      axi_rd(amc_pkg::OFS_ALARM0 + 8'(4 * k), rd, resp);
      `CHK("alarm cfg", wd, rd)
    end
    for (ph = 0; ph < 3; ph++) begin
      for (k = 0; k < 3; k++)
        chan_data[2 * k] <= ((ph == 1) != (k == 1)) ? {thr[k], 4'h0} : {thr[k] - 12'h1, 4'hF};
      wait_done(8);
      axi_rd(amc_pkg::OFS_STATUS, rd, resp);
      if (ph == 0) begin
        axi_wr(amc_pkg::OFS_STATUS, 32'h70, resp);
      end else if (ph == 1) begin
        `CHK("flags set", 3'h7, rd[6:4])
        settle(1);
        `CHK("irq masked", 1'b0, irq_o)
        axi_wr(amc_pkg::OFS_MASK, 32'h0, resp);
        settle(2);
        `CHK("irq unmasked", 1'b1, irq_o)
        axi_wr(amc_pkg::OFS_STATUS, 32'h70, resp);
        settle(2);
        `CHK("irq cleared", 1'b0, irq_o)
      end else begin
        `CHK("flags reverse", 3'h0, rd[6:4])
      end
    end
    $display("alarm test done");
    @(posedge mclk_i);
    vin_present_i <= 1'b0;
    axi_wr(amc_pkg::OFS_MASK, 32'h7, resp);
    axi_wr(amc_pkg::OFS_CTRL, 32'h1, resp);
    settle(20);
    // The sweep starts at the current channel but always ends on the last one.
    chan_data[6] <= 16'($urandom);
    axi_wr(amc_pkg::OFS_CTRL, 32'h3, resp);
    rd = 32'h0;
    n = 0;
    while (rd[0] !== 1'b1 && n < 200) begin
      axi_rd(amc_pkg::OFS_STATUS, rd, resp);
      n++;
    end
    `CHK("manual ready", 1'b1, rd[0])
    settle(2);
    `CHK("ready irq", 1'b1, irq_o)
    axi_rd(amc_pkg::OFS_RESULT0 + 8'h18, rd, resp);
    `CHK("manual result", chan_data[6], rd[15:0])
    axi_wr(amc_pkg::OFS_STATUS, 32'h1, resp);
    settle(2);
    `CHK("ready clear", 1'b0, irq_o)
    @(posedge mclk_i);
    low_power_select_n_i <= 1'b0;
    settle(6);
    `CHK("powered down", 1'b0, conv_power_o)
    n = done_cnt;
    axi_wr(amc_pkg::OFS_CTRL, 32'h3, resp);
    settle(80);
    `CHK("no conversion", n, done_cnt)
    axi_rd(amc_pkg::OFS_CTRL, rd, resp);
    `CHK("start dropped", 1'b0, rd[1])
    $display("manual test done");
    complete_run();
  end
endmodule : tb_amc_top
`default_nettype wire
